// ==== verilog/wdt_pkg.sv ====
// Package: register map, field layout and timing constants of the watchdog unit
package wdt_pkg;
   localparam int         ADDR_W          = 4;
   localparam int         DATA_W          = 8;
   // Register addresses
   localparam logic [3:0] ADDR_WDCTL      = 4'h0;
   localparam logic [3:0] ADDR_CLKCTL     = 4'h1;
   localparam logic [3:0] ADDR_IRQEN      = 4'h2;
   localparam logic [3:0] ADDR_UNLOCK     = 4'h3;
   localparam logic [3:0] ADDR_EVSTAT     = 4'h4;
   localparam logic [3:0] ADDR_EVMASK     = 4'h5;
   // watchdog_control fields
   localparam int         BIT_RESTART     = 0;
   localparam int         BIT_RST_EN      = 1;
   localparam int         BIT_CAUSE       = 2;
   localparam int         BIT_TIMEOUT     = 3;
   // clock_control interval field
   localparam int         BIT_SEL_LO      = 6;
   localparam int         BIT_SEL_HI      = 7;
   // irq enable register: watchdog enable and global enable
   localparam int         BIT_WD_IE       = 4;
   localparam int         BIT_GLOBAL_IE   = 7;
   // Event status bits
   localparam int         EV_TIMEOUT      = 0;
   localparam int         EV_WD_RESET     = 1;
   // Unlock sequence values
   localparam logic [7:0] UNLOCK_KEY1     = 8'hAA;
   localparam logic [7:0] UNLOCK_KEY2     = 8'h55;
   localparam int         UNLOCK_WIN      = 3;
   // Timing
   localparam int         CNT_W           = 26;
   localparam int         TAP0            = 17;
   localparam int         TAP1            = 20;
   localparam int         TAP2            = 23;
   localparam int         TAP3            = 26;
   localparam int         GRACE_CLKS      = 512;
   localparam int         CLKS_PER_MC     = 4;
   localparam int         MC_RESET        = 2;
   localparam int         RST_CLKS        = CLKS_PER_MC * MC_RESET;
   localparam logic [7:0] CLKCTL_RESET    = 8'h00;
endpackage

// ==== verilog/watchdog_timeout_reset_unit.sv ====
// Watchdog divider chain with interval select, time-out flag and forced reset
// ================================================================
// Behaviour
// - The watchdog is a free-running counter on the system clock whose selected tap sets the time-out.
// - Each time-out sets the time-out flag; wd_irq_req is asked only with both enables set, irq with the time-out event mask bit alone.
// - Interrupt and reset paths are enabled separately and may be used in any combination.
// - Writing one to control bit 0 restarts the count and the bit reads back as zero.
// - The interval is chosen by bits 7 and 6 of the clock control register.
// - Codes 00, 01, 10 and 11 give 2^17, 2^20, 2^23 and 2^26 clocks.
// - After reset the interval is the shortest one, 2^17 clocks.
// - With reset enabled and no restart 512 clocks after a time-out, a system reset is raised.
// - The watchdog reset lasts two machine cycles and sets the reset cause flag at bit 2.
// - The time-out flag at bit 3 is cleared by software or by any reset.
// - The reset cause flag clears only by software or power reset and is untouched while disabled.
// - Clearing the reset enable stops only the reset function; the count keeps running.
// - Power reset disables the watchdog reset; a watchdog reset keeps it enabled but restarts the count.
// - As a plain timer the time-out flag is set again at the end of every interval.
// - The time-out flag, reset enable and restart bit are written only after the unlock sequence.
`timescale 1ns/1ps
module watchdog_timeout_reset_unit
   import wdt_pkg::*;
(
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   input  wire logic [wdt_pkg::ADDR_W-1:0] addr,
   input  wire logic [wdt_pkg::DATA_W-1:0] wdata,
   input  wire logic                       wr,
   input  wire logic                       rd,
   output logic      [wdt_pkg::DATA_W-1:0] rdata,
   output logic                            wd_irq_req,
   output logic                            sys_reset,
   output logic                            irq
);
   import wdt_pkg::*;

   // ================================================================
   // Reset synchroniser
   logic       rst_meta;
   logic       rst_sync_n;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // ================================================================
   // Register state
   logic [CNT_W-1:0] count;
   logic [1:0]       interval_sel;
   logic [7:0]       clkctl_low;
   logic             timeout_flag;
   logic             reset_enable;
   logic             reset_cause_flag;
   logic             extended_irq_enable;
   logic             global_irq_enable;
   logic [1:0]       ev_status;
   logic [1:0]       ev_mask;
   logic             grace_active;
   logic [9:0]       grace_cnt;
   logic [3:0]       rst_cnt;
   logic             wd_rst_active;

   typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_OPEN} unlock_e;
   unlock_e          ul_state;
   logic [1:0]       ul_win;

   function automatic logic tap_hit(input logic [CNT_W-1:0] c, input logic [1:0] sel);
      logic [CNT_W-1:0] lim;
      lim = '0;
      case (sel)
         2'b00:   lim = CNT_W'((64'd1 << TAP0) - 64'd1);
         2'b01:   lim = CNT_W'((64'd1 << TAP1) - 64'd1);
         2'b10:   lim = CNT_W'((64'd1 << TAP2) - 64'd1);
         default: lim = CNT_W'((64'd1 << TAP3) - 64'd1);
      endcase
      // A shorter tap chosen while the count is already past it fires at once, not after a wrap
      return c >= lim;
   endfunction

   logic wr_ctl;
   logic unlocked;
   logic restart;
   logic timeout;
   logic grace_done;
   logic fire_reset;

   assign wr_ctl     = wr && (addr == ADDR_WDCTL);
   assign unlocked   = (ul_state == UL_OPEN);
   assign restart    = wr_ctl && unlocked && wdata[BIT_RESTART];
   assign timeout    = tap_hit(count, interval_sel);
   assign grace_done = grace_active && (grace_cnt == 10'(GRACE_CLKS - 1));
   // The reset path alone looks at reset_enable; the interrupt path never does
   assign fire_reset = grace_done && reset_enable && !restart && !wd_rst_active;

   // ================================================================
   // Timed-access unlock: two keys to the unlock address open a short window
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ul_state <= UL_IDLE;
         ul_win   <= 2'b00;
      end else begin
         case (ul_state)
            UL_IDLE: begin
               if (wr && addr == ADDR_UNLOCK && wdata == UNLOCK_KEY1) begin
                  ul_state <= UL_KEY1;
               end
            end
            UL_KEY1: begin
               if (wr && addr == ADDR_UNLOCK && wdata == UNLOCK_KEY2) begin
                  ul_state <= UL_OPEN;
                  ul_win   <= 2'(UNLOCK_WIN);
               end else if (wr) begin
                  ul_state <= UL_IDLE;
               end
            end
            UL_OPEN: begin
               // Window closes after its cycles or after the protected write
               if (wr_ctl || ul_win == 2'b00) begin
                  ul_state <= UL_IDLE;
               end else begin
                  ul_win <= ul_win - 2'b01;
               end
            end
            default: ul_state <= UL_IDLE;
         endcase
      end
   end

   // ================================================================
   // Free-running divider chain
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         count <= '0;
      end else if (restart || fire_reset || timeout) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   // ================================================================
   // Post time-out grace window
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         grace_active <= 1'b0;
         grace_cnt    <= '0;
      end else if (restart) begin
         grace_active <= 1'b0;
         grace_cnt    <= '0;
      end else if (timeout) begin
         grace_active <= 1'b1;
         grace_cnt    <= '0;
      end else if (grace_done) begin
         grace_active <= 1'b0;
      end else if (grace_active) begin
         grace_cnt <= grace_cnt + 10'd1;
      end
   end

   // ================================================================
   // Watchdog-forced reset pulse
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         wd_rst_active <= 1'b0;
         rst_cnt       <= '0;
      end else if (fire_reset) begin
         wd_rst_active <= 1'b1;
         rst_cnt       <= 4'(RST_CLKS - 1);
      end else if (wd_rst_active) begin
         if (rst_cnt == 4'h0) begin
            wd_rst_active <= 1'b0;
         end else begin
            rst_cnt <= rst_cnt - 4'h1;
         end
      end
   end

   // ================================================================
   // Control and status bits
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         timeout_flag <= 1'b0;
      end else if (timeout) begin
         timeout_flag <= 1'b1;
      end else if (fire_reset) begin
         timeout_flag <= 1'b0;
      end else if (wr_ctl && unlocked) begin
         timeout_flag <= wdata[BIT_TIMEOUT];
      end
   end

   // Power reset disables; watchdog reset leaves the enable alone
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reset_enable <= 1'b0;
      end else if (wr_ctl && unlocked) begin
         reset_enable <= wdata[BIT_RST_EN];
      end
   end

   // Cause flag is not protected; software clears it with a plain write
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         reset_cause_flag <= 1'b0;
      end else if (fire_reset) begin
         reset_cause_flag <= 1'b1;
      end else if (wr_ctl) begin
         reset_cause_flag <= wdata[BIT_CAUSE];
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         interval_sel <= CLKCTL_RESET[BIT_SEL_HI:BIT_SEL_LO];
         clkctl_low   <= CLKCTL_RESET;
      end else if (wr && addr == ADDR_CLKCTL) begin
         interval_sel <= wdata[BIT_SEL_HI:BIT_SEL_LO];
         clkctl_low   <= {2'b00, wdata[5:0]};
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         extended_irq_enable <= 1'b0;
         global_irq_enable   <= 1'b0;
      end else if (wr && addr == ADDR_IRQEN) begin
         extended_irq_enable <= wdata[BIT_WD_IE];
         global_irq_enable   <= wdata[BIT_GLOBAL_IE];
      end
   end

   // ================================================================
   // Event status (write one to clear, set wins) and mask
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ev_status <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if ((i == EV_TIMEOUT && timeout) || (i == EV_WD_RESET && fire_reset)) begin
               ev_status[i] <= 1'b1;
            end else if (wr && addr == ADDR_EVSTAT && wdata[i]) begin
               ev_status[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ev_mask <= 2'b00;
      end else if (wr && addr == ADDR_EVMASK) begin
         ev_mask <= wdata[1:0];
      end
   end

   // ================================================================
   // Registered outputs
   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            ADDR_WDCTL:  next_rdata = {4'h0, timeout_flag, reset_cause_flag,
                                       reset_enable, 1'b0};
            ADDR_CLKCTL: next_rdata = {interval_sel, clkctl_low[5:0]};
            ADDR_IRQEN:  next_rdata = {global_irq_enable, 2'b00, extended_irq_enable, 4'h0};
            ADDR_UNLOCK: next_rdata = {7'h00, unlocked};
            ADDR_EVSTAT: next_rdata = {6'h00, ev_status};
            ADDR_EVMASK: next_rdata = {6'h00, ev_mask};
            default:     next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata      <= 8'h00;
         wd_irq_req <= 1'b0;
         sys_reset  <= 1'b0;
         irq        <= 1'b0;
      end else begin
         rdata      <= next_rdata;
         wd_irq_req <= timeout_flag && extended_irq_enable && global_irq_enable;
         sys_reset  <= fire_reset || (wd_rst_active && rst_cnt != 4'h0);
         irq        <= |(ev_status & ev_mask);
      end
   end
endmodule

// ==== bench/watchdog_timeout_reset_unit_assertions.sv ====
// Port-level checker for the watchdog time-out and reset unit
`timescale 1ns/1ps
module wdt_checker
   import wdt_pkg::*;
(
   input wire logic                       ref_clk,
   input wire logic                       rst_n,
   input wire logic [wdt_pkg::ADDR_W-1:0] addr,
   input wire logic [wdt_pkg::DATA_W-1:0] wdata,
   input wire logic                       wr,
   input wire logic                       rd,
   input wire logic [wdt_pkg::DATA_W-1:0] rdata,
   input wire logic                       wd_irq_req,
   input wire logic                       sys_reset,
   input wire logic                       irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ================================================================
   // Helpers
   logic [31:0] quiet_cnt;
   // Raw reset is used, so the count runs two cycles long; only a floor is checked
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         quiet_cnt <= 32'h0;
      end else if (sys_reset) begin
         quiet_cnt <= 32'h0;
      end else begin
         quiet_cnt <= quiet_cnt + 32'h1;
      end
   end
   sequence s_keys;
      wr && addr == ADDR_UNLOCK && wdata == UNLOCK_KEY1 ##1
      wr && addr == ADDR_UNLOCK && wdata == UNLOCK_KEY2;
   endsequence
   sequence s_restart;
      s_keys ##1 (wr && addr == ADDR_WDCTL && wdata[BIT_RESTART]);
   endsequence
   sequence s_disable;
      s_keys ##1 (wr && addr == ADDR_WDCTL && !wdata[BIT_RST_EN]);
   endsequence
   // ================================================================
   // Properties
   property p_rdata_idle;
      !$past(rd) |-> rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("rdata set outside read slot");
   property p_restart_reads0;
      rd && addr == ADDR_WDCTL |=> !rdata[BIT_RESTART];
   endproperty
   a_restart_reads0: assert property (p_restart_reads0)
      else $error("restart bit read back as one");
   property p_sysrst_len;
      $rose(sys_reset) |-> sys_reset [*8] ##1 !sys_reset;
   endproperty
   a_sysrst_len: assert property (p_sysrst_len)
      else $error("system reset length wrong");
   property p_global_off;
      wr && addr == ADDR_IRQEN && !wdata[BIT_GLOBAL_IE] |-> ##2 !wd_irq_req;
   endproperty
   a_global_off: assert property (p_global_off)
      else $error("interrupt request without global enable");
   property p_mask_off;
      wr && addr == ADDR_EVMASK && wdata == 8'h00 |-> ##2 !irq;
   endproperty
   a_mask_off: assert property (p_mask_off)
      else $error("irq high with all events masked");
   property p_restart_quiet;
      s_restart |=> !sys_reset [*8];
   endproperty
   a_restart_quiet: assert property (p_restart_quiet)
      else $error("system reset right after restart");
   property p_disable_quiet;
      s_disable |=> !sys_reset [*8];
   endproperty
   a_disable_quiet: assert property (p_disable_quiet)
      else $error("system reset after reset enable cleared");
   property p_fire_spacing;
      $rose(sys_reset) |-> quiet_cnt >= 32'h0002_0000;
   endproperty
   a_fire_spacing: assert property (p_fire_spacing)
      else $error("system reset sooner than one interval");
endmodule

bind watchdog_timeout_reset_unit wdt_checker i_wdt_checker (.ref_clk(ref_clk), .rst_n(rst_n),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wd_irq_req(wd_irq_req),
   .sys_reset(sys_reset), .irq(irq));

// ==== bench/test_watchdog_timeout_reset_unit.sv ====
// Self-checking bench for the watchdog time-out and reset unit
`timescale 1ns/1ps
module test_watchdog_timeout_reset_unit;
   import wdt_pkg::*;
   logic              ref_clk = 1'b0;
   logic              rst_n   = 1'b0;
   logic [ADDR_W-1:0] addr    = 4'h0;
   logic [DATA_W-1:0] wdata   = 8'h00;
   logic              wr      = 1'b0;
   logic              rd      = 1'b0;
   logic [DATA_W-1:0] rdata;
   logic              wd_irq_req;
   logic              sys_reset;
   logic              irq;
   int                num_errors = 0;
   int                tests_run  = 0;
   int                n;
   always #10 ref_clk = ~ref_clk;
   watchdog_timeout_reset_unit i_watchdog_timeout_reset_unit (.ref_clk(ref_clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .wd_irq_req(wd_irq_req),
      .sys_reset(sys_reset), .irq(irq));
   // ================================================================
   // Bus tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
         num_errors++;
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      rd <= 1'b0;
      wr <= 1'b1;
      @(posedge ref_clk);
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string name);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1;
      chk(name, {24'h0, exp}, {24'h0, rdata});
   endtask
   task automatic idle(input int k);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (k) @(posedge ref_clk);
      #1;
   endtask
   // Keys and the control write go out back to back, well inside the window that the second key opens
   task automatic unlock_wr(input logic [7:0] d);
      wr_reg(ADDR_UNLOCK, UNLOCK_KEY1);
      wr_reg(ADDR_UNLOCK, UNLOCK_KEY2);
      wr_reg(ADDR_WDCTL, d);
   endtask
   task automatic wait_for(input bit sel, input int lim, output int cnt);
      wr <= 1'b0;
      rd <= 1'b0;
      cnt = 0;
      while ((sel ? sys_reset : wd_irq_req) !== 1'b1 && cnt < lim) begin
         @(posedge ref_clk);
         #1;
         cnt++;
      end
   endtask
   task automatic close_out;
      if (num_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ================================================================
   // Tests
   initial begin
      repeat (300000) @(posedge ref_clk);
      num_errors++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd_chk(ADDR_WDCTL, 8'h00, "wdctl_reset");
      rd_chk(ADDR_CLKCTL, 8'h00, "clkctl_reset");
      wr_reg(ADDR_CLKCTL, 8'hC0);
      rd_chk(ADDR_CLKCTL, 8'hC0, "clkctl_sel");
      wr_reg(ADDR_CLKCTL, 8'h00);
      wr_reg(ADDR_WDCTL, 8'h0B);
      rd_chk(ADDR_WDCTL, 8'h00, "locked_write");
      rd_chk(4'hF, 8'h00, "unmapped");
      wr_reg(ADDR_IRQEN, 8'h90);
      wr_reg(ADDR_EVMASK, 8'h00);
      unlock_wr(8'h03);
      wait_for(1'b0, 140000, n);
      chk("interval", 1, (n >= (1 << TAP0) - 2) && (n <= (1 << TAP0) + 4));
      chk("irq_masked", 0, irq);
      wr_reg(ADDR_EVMASK, 8'h01);
      wr_reg(ADDR_IRQEN, 8'h10);
      idle(2);
      chk("irq_unmasked", 1, irq);
      chk("req_no_global", 0, wd_irq_req);
      wr_reg(ADDR_IRQEN, 8'h90);
      idle(2);
      chk("req_both", 1, wd_irq_req);
      rd_chk(ADDR_WDCTL, 8'h0A, "flag_set");
      unlock_wr(8'h03);
      wait_for(1'b1, 700, n);
      chk("no_reset", 700, n);
      unlock_wr(8'h02);
      rd_chk(ADDR_WDCTL, 8'h02, "flag_clear");
      wr_reg(ADDR_EVSTAT, 8'h01);
      idle(2);
      chk("irq_cleared", 0, irq);
      chk("req_cleared", 0, wd_irq_req);
      wait_for(1'b0, 140000, n);
      chk("second_timeout", 1, n < 140000);
      wait_for(1'b1, 600, n);
      chk("grace", 1, (n >= GRACE_CLKS - 3) && (n <= GRACE_CLKS + 3));
      n = 0;
      while (sys_reset === 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("reset_len", RST_CLKS, n);
      rd_chk(ADDR_WDCTL, 8'h06, "after_wd_reset");
      rd_chk(ADDR_EVSTAT, 8'h03, "events");
      chk("irq_event", 1, irq);
      wr_reg(ADDR_WDCTL, 8'h00);
      rd_chk(ADDR_WDCTL, 8'h02, "cause_clear");
      unlock_wr(8'h00);
      rd_chk(ADDR_WDCTL, 8'h00, "reset_disable");
      wr_reg(ADDR_EVSTAT, 8'h03);
      wr_reg(ADDR_EVMASK, 8'h00);
      idle(2);
      chk("irq_final", 0, irq);
      close_out();
   end
endmodule
